// ==== bftc_pkg.sv ====
package bftc_pkg;
  // Clock rates; the pulse timing is kept in master-clock ticks
  localparam int CLK_MHZ = 40;
  localparam int MASTER_MHZ = 160;
  localparam logic [8:0] TICKS_PER_CLK = 9'(MASTER_MHZ / CLK_MHZ);

  // Register addresses on the serial port
  localparam logic [4:0] ADDR_P_FIRST = 5'h08;
  localparam logic [4:0] ADDR_N_FIRST = 5'h10;
  localparam logic [4:0] ADDR_P_ALL = 5'h18;
  localparam logic [4:0] ADDR_N_ALL = 5'h19;
  localparam logic [4:0] ADDR_CTRL = 5'h1a;

  // Global control register layout and reset value
  localparam int CTRL_W = 14;
  localparam logic [13:0] CTRL_RESET = 14'h047f;
  localparam int BIT_RSV = 13;
  localparam int BIT_CW = 12;
  localparam int BIT_IFE = 11;
  localparam int BIT_CME = 10;
  localparam int FD_HI = 9;
  localparam int FD_LO = 3;
  localparam int PL_HI = 2;
  localparam int PL_LO = 0;
  localparam logic [7:0] FD_ZERO_HALF = 8'h80;

  // Pattern storage
  localparam int CHANNELS = 8;
  localparam int PAT_W = 64;
  localparam logic [63:0] P_DEFAULT = 64'h5555_5555_5555_5555;
  localparam logic [63:0] N_DEFAULT = 64'haaaa_aaaa_aaaa_aaaa;

  // Serial frame: one read flag, five address bits, then data
  localparam logic [6:0] CNT_ADDR_LAST = 7'h05;
  localparam logic [6:0] CNT_DATA_FIRST = 7'h06;
  localparam logic [6:0] CNT_MAX = 7'h46;

  typedef enum logic [2:0] {
    BFTC_IDLE = 3'b001,
    BFTC_FIRE = 3'b010,
    BFTC_CW = 3'b100
  } bftc_state_t;

  // Pulses per pattern for each length code
  function automatic logic [6:0] bftc_length(input logic [2:0] code);
    case (code)
      3'h0: bftc_length = 7'h04;
      3'h1: bftc_length = 7'h08;
      3'h2: bftc_length = 7'h10;
      3'h3: bftc_length = 7'h18;
      3'h4: bftc_length = 7'h20;
      3'h5: bftc_length = 7'h28;
      3'h6: bftc_length = 7'h30;
      default: bftc_length = 7'h40;
    endcase
  endfunction : bftc_length
endpackage : bftc_pkg

// ==== bftc_top.sv ====
module bftc_top (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Serial register port
  input wire logic serial_clock_in,
  input wire logic serial_data_in,
  input wire logic serial_latch_enable_in,
  output logic serial_data_out,
  // Fire trigger
  input wire logic transmit_fire_in,
  // Pulser controls
  output logic [7:0] pulse_p_out,
  output logic [7:0] pulse_n_out,
  output logic clock_multiplier_enable_out
);

  logic rst_meta_n;
  logic rst_n;
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [3:0] prev;
  logic sclk_rise;
  logic sle_low;
  logic sle_fall;
  logic sle_rise;
  logic fire_level;
  logic fire_rise;
  logic [6:0] cnt;
  logic read_flag;
  logic [4:0] addr;
  logic [63:0] wdata;
  logic [63:0] rd_shift;
  logic [63:0] pat [2*bftc_pkg::CHANNELS];
  logic [13:0] ctrl;
  logic [4:0] next_addr;
  logic [63:0] rd_value;
  bftc_pkg::bftc_state_t state;
  logic [6:0] bit_idx;
  logic [6:0] len;
  logic [8:0] acc;
  logic [8:0] next_acc;
  logic [7:0] half_div;
  logic tick;
  logic invert;
  logic second_pending;
  logic cw_phase;
  logic [7:0] p_bits;
  logic [7:0] n_bits;

  // Reset release through two flops
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  // Pins are asynchronous: two flops, then a third for edges
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= 4'hf;
      sync2 <= 4'hf;
      prev <= 4'hf;
    end else begin
      sync1 <= {transmit_fire_in, serial_latch_enable_in, serial_data_in, serial_clock_in};
      sync2 <= sync1;
      prev <= sync2;
    end
  end

  // Sampling limits the usable serial clock to well below 20 MHz
  assign sclk_rise = sync2[0] & ~prev[0];
  assign sle_low = ~sync2[2];
  assign sle_fall = ~sync2[2] & prev[2];
  assign sle_rise = sync2[2] & ~prev[2];
  assign fire_level = sync2[3] & prev[3];
  assign fire_rise = sync2[3] & ~prev[3];
  assign next_addr = {addr[3:0], sync2[1]};

  // Read-back source for an address
  always_comb begin
    rd_value = 64'h0;
    if (next_addr == bftc_pkg::ADDR_CTRL) begin
      rd_value = {50'h0, ctrl};
    end else if (next_addr >= bftc_pkg::ADDR_P_FIRST && next_addr < bftc_pkg::ADDR_P_ALL) begin
      rd_value = pat[4'(next_addr - bftc_pkg::ADDR_P_FIRST)];
    end else if (next_addr == bftc_pkg::ADDR_P_ALL) begin
      rd_value = pat[0];
    end else if (next_addr == bftc_pkg::ADDR_N_ALL) begin
      rd_value = pat[bftc_pkg::CHANNELS];
    end
  end

  // Serial frame capture: flag, address MSB first, data LSB first
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 7'h0;
      read_flag <= 1'b0;
      addr <= 5'h0;
      wdata <= 64'h0;
    end else if (sle_fall) begin
      cnt <= 7'h0;
      wdata <= 64'h0;
    end else if (sle_low && sclk_rise && cnt != bftc_pkg::CNT_MAX) begin
      cnt <= cnt + 7'h1;
      if (cnt == 7'h0) begin
        read_flag <= sync2[1];
      end else if (cnt < bftc_pkg::CNT_DATA_FIRST) begin
        addr <= next_addr;
      end else begin
        wdata[6'(cnt - bftc_pkg::CNT_DATA_FIRST)] <= sync2[1];
      end
    end
  end

  // Read data: loaded with the last address bit, shifted per clock
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      rd_shift <= 64'h0;
    end else if (sle_low && sclk_rise && read_flag) begin
      if (cnt == bftc_pkg::CNT_ADDR_LAST) begin
        rd_shift <= rd_value;
      end else if (cnt >= bftc_pkg::CNT_DATA_FIRST) begin
        rd_shift <= {1'b0, rd_shift[63:1]};
      end
    end
  end
  assign serial_data_out = rd_shift[0];

  // Control register commit at latch rise; reserved bit kept zero
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= bftc_pkg::CTRL_RESET;
    end else if (sle_rise && !read_flag && cnt >= bftc_pkg::CNT_DATA_FIRST && addr == bftc_pkg::ADDR_CTRL) begin
      ctrl <= wdata[13:0] & ~(14'h1 << bftc_pkg::BIT_RSV);
    end
  end

  // Pattern commit; frozen while continuous wave is on
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < bftc_pkg::CHANNELS; i++) begin
        pat[i] <= bftc_pkg::P_DEFAULT;
        pat[i + bftc_pkg::CHANNELS] <= bftc_pkg::N_DEFAULT;
      end
    end else if (sle_rise && !read_flag && cnt >= bftc_pkg::CNT_DATA_FIRST && !ctrl[bftc_pkg::BIT_CW]) begin
      for (int i = 0; i < 2 * bftc_pkg::CHANNELS; i++) begin
        if (addr == 5'(i) + bftc_pkg::ADDR_P_FIRST) begin
          pat[i] <= wdata;
        end else if (addr == bftc_pkg::ADDR_P_ALL && i < bftc_pkg::CHANNELS) begin
          pat[i] <= wdata;
        end else if (addr == bftc_pkg::ADDR_N_ALL && i >= bftc_pkg::CHANNELS) begin
          pat[i] <= wdata;
        end
      end
    end
  end

  assign clock_multiplier_enable_out = ctrl[bftc_pkg::BIT_CME];
  assign len = bftc_pkg::bftc_length(ctrl[bftc_pkg::PL_HI:bftc_pkg::PL_LO]);

  // Bit period in master ticks is the field value; zero means 128
  assign half_div = (ctrl[bftc_pkg::FD_HI:bftc_pkg::FD_LO] == 7'h0) ? bftc_pkg::FD_ZERO_HALF
                    : {1'b0, ctrl[bftc_pkg::FD_HI:bftc_pkg::FD_LO]};
  assign next_acc = acc + bftc_pkg::TICKS_PER_CLK;
  // Fractional accumulator; fields below four saturate at one bit per clock
  assign tick = (state != bftc_pkg::BFTC_IDLE) && ctrl[bftc_pkg::BIT_CME] && next_acc >= {1'b0, half_div};

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      acc <= 9'h0;
    end else if (state == bftc_pkg::BFTC_IDLE) begin
      acc <= 9'h0;
    end else if (ctrl[bftc_pkg::BIT_CME]) begin
      // Clamp stops fields below four from piling up until the sum wraps and drops a tick
      if (!tick) begin
        acc <= next_acc;
      end else if (next_acc - {1'b0, half_div} >= {1'b0, half_div}) begin
        acc <= 9'h0;
      end else begin
        acc <= next_acc - {1'b0, half_div};
      end
    end
  end

  // Same bit index for every channel, LSB first
  always_comb begin
    for (int c = 0; c < bftc_pkg::CHANNELS; c++) begin
      p_bits[c] = pat[c][6'(bit_idx)];
      n_bits[c] = pat[c + bftc_pkg::CHANNELS][6'(bit_idx)];
    end
  end

  // Invert-fire pairing: serial activity restarts the pair
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      second_pending <= 1'b0;
    end else if (sle_fall || !ctrl[bftc_pkg::BIT_IFE]) begin
      second_pending <= 1'b0;
    end else if (state == bftc_pkg::BFTC_IDLE && fire_rise && !ctrl[bftc_pkg::BIT_CW]) begin
      second_pending <= ~second_pending;
    end
  end

  // Firing sequencer
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      state <= bftc_pkg::BFTC_IDLE;
      bit_idx <= 7'h0;
      invert <= 1'b0;
      cw_phase <= 1'b0;
    end else begin
      case (state)
        bftc_pkg::BFTC_IDLE: begin
          bit_idx <= 7'h0;
          cw_phase <= 1'b0;
          if (fire_rise) begin
            if (ctrl[bftc_pkg::BIT_CW]) begin
              state <= bftc_pkg::BFTC_CW;
            end else begin
              state <= bftc_pkg::BFTC_FIRE;
              invert <= ctrl[bftc_pkg::BIT_IFE] & second_pending;
            end
          end
        end
        bftc_pkg::BFTC_FIRE: begin
          if (tick) begin
            if (bit_idx + 7'h1 == len) begin
              state <= bftc_pkg::BFTC_IDLE;
            end else begin
              bit_idx <= bit_idx + 7'h1;
            end
          end
        end
        bftc_pkg::BFTC_CW: begin
          if (!fire_level) begin
            state <= bftc_pkg::BFTC_IDLE;
          end else if (tick) begin
            cw_phase <= ~cw_phase;
          end
        end
        default: state <= bftc_pkg::BFTC_IDLE;
      endcase
    end
  end

  // Registered pulser drive; idle is all low
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      pulse_p_out <= 8'h0;
      pulse_n_out <= 8'h0;
    end else if (state == bftc_pkg::BFTC_FIRE) begin
      pulse_p_out <= p_bits ^ {8{invert}};
      pulse_n_out <= n_bits ^ {8{invert}};
    end else if (state == bftc_pkg::BFTC_CW) begin
      pulse_p_out <= {8{~cw_phase}};
      pulse_n_out <= {8{cw_phase}};
    end else begin
      pulse_p_out <= 8'h0;
      pulse_n_out <= 8'h0;
    end
  end
endmodule : bftc_top

// ==== bftc_top_props.sv ====
module bftc_top_props (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Serial port
  input wire logic serial_clock_in,
  input wire logic serial_data_in,
  input wire logic serial_latch_enable_in,
  input wire logic serial_data_out,
  // Fire and pulser lines
  input wire logic transmit_fire_in,
  input wire logic [7:0] pulse_p_out,
  input wire logic [7:0] pulse_n_out,
  input wire logic clock_multiplier_enable_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);
  // Any pulser line active
  wire logic busy = |{pulse_p_out, pulse_n_out};

  // Quiet pulsers and multiplier on while reset drains
  a_reset_idle: assert property (
    $rose(rst_n_in) |-> (clock_multiplier_enable_out && !busy) [*2]) else $error("reset state wrong");
  a_start_after_fire: assert property (
    $rose(busy) |-> $past(transmit_fire_in, 3)) else $error("start without fire");
  a_start_fresh_edge: assert property (
    $rose(busy) |-> !$past(transmit_fire_in, 9)) else $error("start without edge");
  a_no_retrigger: assert property (
    $fell(busy) && transmit_fire_in |-> !busy [*5]) else $error("pattern restarted");
  a_cw_stops_low: assert property (
    $fell(transmit_fire_in) |-> ##[0:300] !busy) else $error("output kept running");
  a_cme_after_frame: assert property (
    $changed(clock_multiplier_enable_out)
      |-> $past(serial_latch_enable_in) && !$past(serial_latch_enable_in, 5)) else $error("enable moved alone");
  a_channels_lock: assert property (
    busy |-> pulse_p_out inside {8'h00, 8'hff} && pulse_n_out inside {8'h00, 8'hff}) else $error("channels apart");
  // Read-back only moves inside a frame
  a_readback_quiet: assert property (
    $changed(serial_data_out) |-> !$past(serial_latch_enable_in, 3)) else $error("read-back moved");

  c_fire: cover property ($rose(busy));
  c_done: cover property ($fell(busy) && transmit_fire_in);
  c_cme: cover property ($fell(clock_multiplier_enable_out));
endmodule : bftc_top_props

bind bftc_top bftc_top_props chk (.clock_in(clock_in), .rst_n_in(rst_n_in), .serial_clock_in(serial_clock_in),
  .serial_data_in(serial_data_in), .serial_latch_enable_in(serial_latch_enable_in),
  .serial_data_out(serial_data_out), .transmit_fire_in(transmit_fire_in), .pulse_p_out(pulse_p_out),
  .pulse_n_out(pulse_n_out), .clock_multiplier_enable_out(clock_multiplier_enable_out));

// ==== bftc_host.sv ====
module bftc_host (
  // Clock
  input wire logic clk_in,
  // Read-back pin from the device
  input wire logic sdata_in,
  // Pins toward the device
  output logic sclk_out,
  output logic sdata_out,
  output logic latch_n_out,
  output logic fire_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle pins: latch high, fire low
  initial begin
    sclk_out = 1'b0;
    sdata_out = 1'b0;
    latch_n_out = 1'b1;
    fire_out = 1'b0;
  end

  // Write frame: flag, address MSB first, data LSB first; 4 clocks per level
  task automatic send(input logic [4:0] addr, input logic [63:0] data, input int nbits);
    latch_n_out = 1'b0;
    for (int i = 0; i < 6 + nbits; i++) begin
      sdata_out = (i == 0) ? 1'b0 : (i < 6) ? addr[5 - i] : data[i - 6];
      repeat (4) @(negedge clk_in);
      sclk_out = 1'b1;
      repeat (4) @(negedge clk_in);
      sclk_out = 1'b0;
    end
    latch_n_out = 1'b1;
    sdata_out = ~sdata_out; // Stale data never lingers
    repeat (8) @(negedge clk_in);
  endtask : send

  // Read frame: flag one, address MSB first; each data bit taken just before its clock rise
  task automatic fetch(input logic [4:0] addr, input int nbits, output logic [63:0] data);
    data = 64'h0;
    latch_n_out = 1'b0;
    for (int i = 0; i < 6 + nbits; i++) begin
      sdata_out = (i == 0) ? 1'b1 : (i < 6) ? addr[5 - i] : 1'b0;
      repeat (4) @(negedge clk_in);
      if (i >= 6) begin
        data[i - 6] = sdata_in;
      end
      sclk_out = 1'b1;
      repeat (4) @(negedge clk_in);
      sclk_out = 1'b0;
    end
    latch_n_out = 1'b1;
    sdata_out = ~sdata_out; // Stale data never lingers
    repeat (8) @(negedge clk_in);
  endtask : fetch

  // One rising edge per firing
  task automatic set_fire(input logic v);
    fire_out = v;
  endtask : set_fire
endmodule : bftc_host

// ==== bftc_top_test.sv ====
module bftc_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic sclk, sdata, latch_n, fire, sdo, cme;
  logic [7:0] p, n;
  int bad_count = 0;
  int check_count = 0;

  // 40 MHz clock
  always #12.5 clock_in = ~clock_in;

  bftc_host host (.clk_in(clock_in), .sdata_in(sdo), .sclk_out(sclk), .sdata_out(sdata), .latch_n_out(latch_n),
    .fire_out(fire));
  bftc_top uut (.clock_in(clock_in), .rst_n_in(rst_n_in), .serial_clock_in(sclk), .serial_data_in(sdata),
    .serial_latch_enable_in(latch_n), .serial_data_out(sdo), .transmit_fire_in(fire), .pulse_p_out(p),
    .pulse_n_out(n), .clock_multiplier_enable_out(cme));

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : check8

  task automatic check64(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t read %h exp %h", $time, got, exp);
    end
  endtask : check64

  task automatic give_verdict;
    $display("checks %0d bad %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  // Control write; reserved top bit always zero
  task automatic ctrl(input logic cw, invert_fire_enable, en, input logic [6:0] fd, input logic [2:0] pl);
    host.send(bftc_pkg::ADDR_CTRL, {51'h0, cw, invert_fire_enable, en, fd, pl}, bftc_pkg::CTRL_W);
  endtask : ctrl

  // Bounded wait for the first active pulse
  task automatic wait_busy;
    for (int t = 0; t < 40 && {p, n} === 16'h0000; t++) @(negedge clock_in);
  endtask : wait_busy

  // Fire and step through four bits of per clocks each
  task automatic fire_check(input logic [3:0] pp, nn, input int per);
    host.set_fire(1'b1);
    wait_busy();
    for (int i = 0; i < 4; i++) begin
      check8(p, {8{pp[i]}});
      check8(n, {8{nn[i]}});
      repeat (per) @(negedge clock_in);
    end
    check8(p | n, 8'h00);
    host.set_fire(1'b0);
    repeat (12) @(negedge clock_in);
  endtask : fire_check

  // Four-pulse patterns; unmapped write must not disturb them
  task automatic t_normal;
    ctrl(1'b0, 1'b0, 1'b1, 7'h04, 3'h0);
    host.send(bftc_pkg::ADDR_P_ALL, 64'h6, 4);
    host.send(bftc_pkg::ADDR_N_ALL, 64'h9, 4);
    host.send(5'h1f, 64'hf, 4);
    fire_check(4'h6, 4'h9, 1);
    fire_check(4'h6, 4'h9, 1);
  endtask : t_normal

  task automatic t_divider;
    ctrl(1'b0, 1'b0, 1'b1, 7'h08, 3'h0);
    fire_check(4'h6, 4'h9, 2);
    ctrl(1'b0, 1'b0, 1'b1, 7'h00, 3'h0);
    fire_check(4'h6, 4'h9, 32);
  endtask : t_divider

  // No serial traffic between the pair of firings
  task automatic t_invert;
    ctrl(1'b0, 1'b1, 1'b1, 7'h04, 3'h0);
    fire_check(4'h6, 4'h9, 1);
    fire_check(4'h9, 4'h6, 1);
  endtask : t_invert

  // Pattern writes during continuous wave are dropped
  task automatic t_cw;
    ctrl(1'b1, 1'b0, 1'b1, 7'h04, 3'h0);
    host.send(bftc_pkg::ADDR_P_ALL, 64'hf, 4);
    host.send(bftc_pkg::ADDR_N_ALL, 64'h0, 4);
    host.set_fire(1'b1);
    wait_busy();
    for (int i = 0; i < 6; i++) begin
      check8(p, i[0] ? 8'h00 : 8'hff);
      check8(n, i[0] ? 8'hff : 8'h00);
      @(negedge clock_in);
    end
    host.set_fire(1'b0);
    repeat (12) @(negedge clock_in);
    check8(p | n, 8'h00);
    ctrl(1'b0, 1'b0, 1'b1, 7'h04, 3'h0);
    fire_check(4'h6, 4'h9, 1);
  endtask : t_cw

  task automatic t_cme;
    ctrl(1'b0, 1'b0, 1'b0, 7'h04, 3'h0);
    check8({7'h00, cme}, 8'h00);
    ctrl(1'b0, 1'b0, 1'b1, 7'h04, 3'h0);
    check8({7'h00, cme}, 8'h01);
  endtask : t_cme

  // Read-back after t_cme; patterns must still hold what was written before continuous wave
  task automatic t_readback;
    logic [63:0] got;
    host.fetch(bftc_pkg::ADDR_CTRL, bftc_pkg::CTRL_W, got);
    check64(got, 64'h0420);
    host.fetch(bftc_pkg::ADDR_P_FIRST, 4, got);
    check64(got, 64'h6);
    host.fetch(bftc_pkg::ADDR_N_ALL, 4, got);
    check64(got, 64'h9);
  endtask : t_readback

  // Main sequence
  initial begin
    repeat (5) @(negedge clock_in);
    rst_n_in = 1'b1;
    repeat (4) @(negedge clock_in);
    check8({7'h00, cme}, 8'h01);
    t_normal();
    t_divider();
    t_invert();
    t_cw();
    t_cme();
    t_readback();
    give_verdict();
  end

  // Watchdog: run needs about 2400 clocks, allow 20000
  initial begin
    #500000;
    bad_count++;
    $display("BAD %0t timeout", $time);
    give_verdict();
  end
endmodule : bftc_top_test
